// [ord_pkg.sv]
package ord_pkg;
	// register indices, byte address is four times the index
	localparam int             REG_ADDR_W          = 12;
	localparam int             REG_IDX_W           = 10;
	localparam logic [9:0]     IDX_LEVEL_LIMIT_I   = 10'h211;
	localparam logic [9:0]     IDX_LEVEL_LIMIT_Q   = 10'h212;
	localparam logic [9:0]     IDX_RANGE_PIN_CFG   = 10'h213;
	localparam logic [9:0]     IDX_IRQ_STATUS      = 10'h220;
	localparam logic [9:0]     IDX_IRQ_MASK        = 10'h221;
	// reset values
	localparam logic [7:0]     RST_LEVEL_LIMIT_I   = 8'hF2;
	localparam logic [7:0]     RST_LEVEL_LIMIT_Q   = 8'hAB;
	localparam logic [7:0]     RST_RANGE_PIN_CFG   = 8'h07;
	localparam logic [3:0]     RST_IRQ_MASK        = 4'h0;
	// config field layout
	localparam int             CFG_ENABLE_BIT      = 3;
	localparam int             CFG_EXP_LSB         = 0;
	localparam int             CFG_EXP_W           = 3;
	// detection and stretch
	localparam int             MAG_BITS            = 8;
	localparam int             LIMIT_SCALE         = 256;
	localparam int             STRETCH_BASE        = 8;
	localparam int             STRETCH_CNT_W       = 11;
	localparam int             LANES               = 4;
	// axi responses
	localparam logic [1:0]     RESP_OKAY           = 2'h0;
	localparam logic [1:0]     RESP_SLVERR         = 2'h2;
endpackage : ord_pkg

// [ord_overrange_detector.sv]
`timescale 1ns/10ps
module ord_overrange_detector
	import ord_pkg::*;
#(
	parameter int SAMPLE_W = 16
)(
	// clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_in,
	// down-converter samples, channel a
	input  wire logic                  a_valid_in,
	input  wire logic [SAMPLE_W-1:0]   a_i_in,
	input  wire logic [SAMPLE_W-1:0]   a_q_in,
	// down-converter samples, channel b
	input  wire logic                  b_valid_in,
	input  wire logic [SAMPLE_W-1:0]   b_i_in,
	input  wire logic [SAMPLE_W-1:0]   b_q_in,
	// samples with control bits attached
	output logic                       a_valid_out,
	output logic [SAMPLE_W-1:0]        a_i_out,
	output logic [SAMPLE_W-1:0]        a_q_out,
	output logic [1:0]                 a_ctrl_out,
	output logic                       b_valid_out,
	output logic [SAMPLE_W-1:0]        b_i_out,
	output logic [SAMPLE_W-1:0]        b_q_out,
	output logic [1:0]                 b_ctrl_out,
	// over-range pins
	output logic                       range_flag_a_zero_out,
	output logic                       range_flag_a_one_out,
	output logic                       range_flag_b_zero_out,
	output logic                       range_flag_b_one_out,
	// interrupt
	output logic                       irq_out,
	// axi4-lite write address
	input  wire logic                  s_axi_awvalid_in,
	output logic                       s_axi_awready_out,
	input  wire logic [REG_ADDR_W-1:0] s_axi_awaddr_in,
	// axi4-lite write data
	input  wire logic                  s_axi_wvalid_in,
	output logic                       s_axi_wready_out,
	input  wire logic [31:0]           s_axi_wdata_in,
	input  wire logic [3:0]            s_axi_wstrb_in,
	// axi4-lite write response
	output logic                       s_axi_bvalid_out,
	input  wire logic                  s_axi_bready_in,
	output logic [1:0]                 s_axi_bresp_out,
	// axi4-lite read address
	input  wire logic                  s_axi_arvalid_in,
	output logic                       s_axi_arready_out,
	input  wire logic [REG_ADDR_W-1:0] s_axi_araddr_in,
	// axi4-lite read data
	output logic                       s_axi_rvalid_out,
	input  wire logic                  s_axi_rready_in,
	output logic [31:0]                s_axi_rdata_out,
	output logic [1:0]                 s_axi_rresp_out
);

	// saturating magnitude, top bits only; most negative code maps to full scale
	function automatic logic [MAG_BITS-1:0] mag_top(input logic [SAMPLE_W-1:0] s);
		logic [SAMPLE_W-1:0] a;
		a = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
		mag_top = a[SAMPLE_W-1] ? '1 : a[SAMPLE_W-2 -: MAG_BITS];
	endfunction : mag_top

	// register file
	logic [7:0]                level_limit_i;
	logic [7:0]                level_limit_q;
	logic [7:0]                range_pin_config;
	logic [LANES-1:0]          irq_status;
	logic [LANES-1:0]          irq_mask;
	logic [7:0]                next_level_limit_i;
	logic [7:0]                next_level_limit_q;
	logic [7:0]                next_range_pin_config;
	logic [LANES-1:0]          next_irq_status;
	logic [LANES-1:0]          next_irq_mask;

	// bus state
	logic                      aw_hold;
	logic [REG_ADDR_W-1:0]     aw_addr;
	logic                      w_hold;
	logic [31:0]               w_data;
	logic [3:0]                w_strb;
	logic                      bvalid;
	logic [1:0]                bresp;
	logic                      rvalid;
	logic [31:0]               rdata;
	logic [1:0]                rresp;
	logic                      next_aw_hold;
	logic [REG_ADDR_W-1:0]     next_aw_addr;
	logic                      next_w_hold;
	logic [31:0]               next_w_data;
	logic [3:0]                next_w_strb;
	logic                      next_bvalid;
	logic [1:0]                next_bresp;
	logic                      next_rvalid;
	logic [31:0]               next_rdata;
	logic [1:0]                next_rresp;

	// datapath state
	logic [STRETCH_CNT_W-1:0]  stretch_cnt [LANES];
	logic [STRETCH_CNT_W-1:0]  next_stretch_cnt [LANES];
	logic [LANES-1:0]          pin;
	logic [LANES-1:0]          next_pin;
	logic [LANES-1:0]          ctrl;
	logic [LANES-1:0]          next_ctrl;
	logic [SAMPLE_W-1:0]       smp [LANES];
	logic [SAMPLE_W-1:0]       next_smp [LANES];
	logic [1:0]                vld;
	logic [1:0]                next_vld;
	logic                      irq;
	logic                      next_irq;

	// combinational helpers
	logic [SAMPLE_W-1:0]       lane_in [LANES];
	logic [LANES-1:0]          lane_vld;
	logic [LANES-1:0]          hit;
	logic                      aw_take;
	logic                      w_take;
	logic                      do_write;
	logic [REG_ADDR_W-1:0]     wr_addr;
	logic [31:0]               wr_data;
	logic [3:0]                wr_strb;
	logic [REG_IDX_W-1:0]      wr_idx;
	logic [REG_IDX_W-1:0]      rd_idx;
	logic                      ar_take;
	logic [LANES-1:0]          status_clr;
	logic [STRETCH_CNT_W-1:0]  stretch_len;

	assign lane_in[0] = a_i_in;
	assign lane_in[1] = a_q_in;
	assign lane_in[2] = b_i_in;
	assign lane_in[3] = b_q_in;
	assign lane_vld   = {b_valid_in, b_valid_in, a_valid_in, a_valid_in};

	// even lanes are i paths, odd lanes are q paths
	always_comb
	begin
		for (int n = 0; n < LANES; n++)
		begin
			if (n % 2 == 0)
				hit[n] = lane_vld[n] && (mag_top(lane_in[n]) >= level_limit_i);
			else
				hit[n] = lane_vld[n] && (mag_top(lane_in[n]) >= level_limit_q);
		end
	end

	// shift keeps the width; longest pulse is 8 << 7 = 1024 cycles
	assign stretch_len = STRETCH_CNT_W'(STRETCH_BASE)
		<< range_pin_config[CFG_EXP_LSB +: CFG_EXP_W];

	// bus handshakes
	assign s_axi_awready_out = !aw_hold && !bvalid;
	assign s_axi_wready_out  = !w_hold && !bvalid;
	assign s_axi_arready_out = !rvalid;
	assign aw_take  = s_axi_awvalid_in && s_axi_awready_out;
	assign w_take   = s_axi_wvalid_in && s_axi_wready_out;
	assign ar_take  = s_axi_arvalid_in && s_axi_arready_out;
	assign do_write = (aw_hold || aw_take) && (w_hold || w_take) && !bvalid;
	assign wr_addr  = aw_hold ? aw_addr : s_axi_awaddr_in;
	assign wr_data  = w_hold ? w_data : s_axi_wdata_in;
	assign wr_strb  = w_hold ? w_strb : s_axi_wstrb_in;
	assign wr_idx   = wr_addr[REG_ADDR_W-1:2];
	assign rd_idx   = s_axi_araddr_in[REG_ADDR_W-1:2];

	always_comb
	begin
		next_aw_hold          = aw_hold;
		next_aw_addr          = aw_addr;
		next_w_hold           = w_hold;
		next_w_data           = w_data;
		next_w_strb           = w_strb;
		next_bvalid           = bvalid;
		next_bresp            = bresp;
		next_rvalid           = rvalid;
		next_rdata            = rdata;
		next_rresp            = rresp;
		next_level_limit_i    = level_limit_i;
		next_level_limit_q    = level_limit_q;
		next_range_pin_config = range_pin_config;
		next_irq_mask         = irq_mask;
		status_clr            = '0;
		if (aw_take)
		begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr_in;
		end
		if (w_take)
		begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata_in;
			next_w_strb = s_axi_wstrb_in;
		end
		if (do_write)
		begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			unique case (wr_idx)
				IDX_LEVEL_LIMIT_I:
					if (wr_strb[0])
						next_level_limit_i = wr_data[7:0];
				IDX_LEVEL_LIMIT_Q:
					if (wr_strb[0])
						next_level_limit_q = wr_data[7:0];
				IDX_RANGE_PIN_CFG:
					if (wr_strb[0])
						next_range_pin_config = wr_data[7:0];
				IDX_IRQ_STATUS:
					if (wr_strb[0])
						status_clr = wr_data[LANES-1:0];
				IDX_IRQ_MASK:
					if (wr_strb[0])
						next_irq_mask = wr_data[LANES-1:0];
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		else if (bvalid && s_axi_bready_in)
			next_bvalid = 1'b0;
		if (ar_take)
		begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			unique case (rd_idx)
				IDX_LEVEL_LIMIT_I: next_rdata = {24'h000000, level_limit_i};
				IDX_LEVEL_LIMIT_Q: next_rdata = {24'h000000, level_limit_q};
				IDX_RANGE_PIN_CFG: next_rdata = {24'h000000, range_pin_config};
				IDX_IRQ_STATUS:    next_rdata = {28'h0000000, irq_status};
				IDX_IRQ_MASK:      next_rdata = {28'h0000000, irq_mask};
				default:
				begin
					next_rdata = 32'h00000000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid && s_axi_rready_in)
			next_rvalid = 1'b0;
	end

	// detection, stretch and pins
	always_comb
	begin
		next_smp[0] = a_i_in;
		next_smp[1] = a_q_in;
		next_smp[2] = b_i_in;
		next_smp[3] = b_q_in;
		next_vld    = {b_valid_in, a_valid_in};
		// control bits follow the samples whatever the pin enable says
		next_ctrl   = hit;
		for (int n = 0; n < LANES; n++)
		begin
			if (hit[n])
				next_stretch_cnt[n] = stretch_len;
			else if (stretch_cnt[n] != '0)
				next_stretch_cnt[n] = stretch_cnt[n] - 1'b1;
			else
				next_stretch_cnt[n] = stretch_cnt[n];
			// counter keeps running while disabled so enabling shows live state
			next_pin[n] = range_pin_config[CFG_ENABLE_BIT]
				&& (next_stretch_cnt[n] != '0);
		end
		// set wins over a clear in the same cycle
		next_irq_status = (irq_status & ~status_clr) | hit;
		next_irq        = |(next_irq_status & irq_mask);
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			aw_hold          <= 1'b0;
			aw_addr          <= '0;
			w_hold           <= 1'b0;
			w_data           <= 32'h00000000;
			w_strb           <= 4'h0;
			bvalid           <= 1'b0;
			bresp            <= RESP_OKAY;
			rvalid           <= 1'b0;
			rdata            <= 32'h00000000;
			rresp            <= RESP_OKAY;
			level_limit_i    <= RST_LEVEL_LIMIT_I;
			level_limit_q    <= RST_LEVEL_LIMIT_Q;
			range_pin_config <= RST_RANGE_PIN_CFG;
			irq_status       <= '0;
			irq_mask         <= RST_IRQ_MASK;
			pin              <= '0;
			ctrl             <= '0;
			vld              <= 2'h0;
			irq              <= 1'b0;
			stretch_cnt      <= '{default: '0};
			smp              <= '{default: '0};
		end
		else
		begin
			aw_hold          <= next_aw_hold;
			aw_addr          <= next_aw_addr;
			w_hold           <= next_w_hold;
			w_data           <= next_w_data;
			w_strb           <= next_w_strb;
			bvalid           <= next_bvalid;
			bresp            <= next_bresp;
			rvalid           <= next_rvalid;
			rdata            <= next_rdata;
			rresp            <= next_rresp;
			level_limit_i    <= next_level_limit_i;
			level_limit_q    <= next_level_limit_q;
			range_pin_config <= next_range_pin_config;
			irq_status       <= next_irq_status;
			irq_mask         <= next_irq_mask;
			pin              <= next_pin;
			ctrl             <= next_ctrl;
			vld              <= next_vld;
			irq              <= next_irq;
			stretch_cnt      <= next_stretch_cnt;
			smp              <= next_smp;
		end
	end

	// outputs
	assign s_axi_bvalid_out      = bvalid;
	assign s_axi_bresp_out       = bresp;
	assign s_axi_rvalid_out      = rvalid;
	assign s_axi_rdata_out       = rdata;
	assign s_axi_rresp_out       = rresp;
	assign {b_valid_out, a_valid_out} = vld;
	assign a_i_out               = smp[0];
	assign a_q_out               = smp[1];
	assign b_i_out               = smp[2];
	assign b_q_out               = smp[3];
	assign {b_ctrl_out, a_ctrl_out} = ctrl;
	assign {range_flag_b_one_out, range_flag_b_zero_out,
		range_flag_a_one_out, range_flag_a_zero_out} = pin;
	assign irq_out               = irq;

endmodule : ord_overrange_detector

// [ord_overrange_detector_assertions.sv]
`timescale 1ns/10ps
module ord_overrange_detector_chk #(
	parameter int SAMPLE_W = 16
)(
	// clock and reset
	input	wire logic			clk_sys_in,
	input	wire logic			rst_in,
	// sample path
	input	wire logic			a_valid_in,
	input	wire logic [SAMPLE_W-1:0]	a_i_in,
	input	wire logic			b_valid_in,
	input	wire logic [SAMPLE_W-1:0]	b_q_in,
	input	wire logic			a_valid_out,
	input	wire logic [SAMPLE_W-1:0]	a_i_out,
	input	wire logic [1:0]		a_ctrl_out,
	input	wire logic [1:0]		b_ctrl_out,
	// pins
	input	wire logic			range_flag_a_zero_out,
	input	wire logic			range_flag_b_one_out,
	// register bus
	input	wire logic			s_axi_awvalid_in,
	input	wire logic			s_axi_awready_out,
	input	wire logic			s_axi_wvalid_in,
	input	wire logic			s_axi_wready_out,
	input	wire logic			s_axi_bvalid_out,
	input	wire logic			s_axi_arvalid_in,
	input	wire logic			s_axi_arready_out,
	input	wire logic			s_axi_rvalid_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	sequence wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence rd_taken;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	// full-scale codes trip whatever limit is set
	i_hit_a: assert property (a_valid_in && a_i_in == {1'h0, {(SAMPLE_W-1){1'h1}}}
		|=> a_ctrl_out[0]) else $error("i full scale not flagged");
	q_hit_a: assert property (b_valid_in && b_q_in == {1'h1, {(SAMPLE_W-1){1'h0}}}
		|=> b_ctrl_out[1]) else $error("q most negative not flagged");
	idle_ctrl_a: assert property (!a_valid_in |=> a_ctrl_out == 2'h0)
		else $error("ctrl set on idle sample");
	sample_pass_a: assert property (a_valid_in |=> a_valid_out && a_i_out == $past(a_i_in))
		else $error("sample not passed on");
	a_pin_min_a: assert property ($rose(range_flag_a_zero_out) |-> range_flag_a_zero_out[*8])
		else $error("pin a pulse too short");
	b_pin_min_a: assert property ($rose(range_flag_b_one_out) |-> range_flag_b_one_out[*8])
		else $error("pin b pulse too short");
	wr_resp_a: assert property (wr_taken |=> s_axi_bvalid_out)
		else $error("write not answered");
	rd_resp_a: assert property (rd_taken |=> s_axi_rvalid_out)
		else $error("read not answered");
	wr_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken during response");
	rd_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken during response");
endmodule : ord_overrange_detector_chk

// [ord_pin_monitor.sv]
`timescale 1ns/10ps
module ord_pin_monitor (
	input	wire logic		clk_sys_in,
	input	wire logic		rst_in,
	input	wire logic [3:0]	pins_in,
	output	logic [3:0]		done_out,
	output	logic [15:0]		len_out [4]
);
	logic	[15:0]	cnt [4];
	// measures each pulse, reports its length once it falls
	always_ff @(posedge clk_sys_in)
	begin
		for (int l = 0; l < 4; l++)
		begin
			done_out[l] <= !rst_in && !pins_in[l] && cnt[l] != 16'h0;
			len_out[l] <= cnt[l];
			cnt[l] <= (rst_in || !pins_in[l]) ? 16'h0 : cnt[l] + 16'h1;
		end
	end
endmodule : ord_pin_monitor

// [tb_overrange_detector.sv]
`timescale 1ns/10ps
module tb_overrange_detector
	import ord_pkg::*;
;
	logic		clk_sys_in = 1'h0, rst_in = 1'h1, a_valid_in = 1'h0, b_valid_in = 1'h0;
	logic	[15:0]	a_i_in = 16'h0, a_q_in = 16'h0, b_i_in = 16'h0, b_q_in = 16'h0;
	logic	[15:0]	a_i_out, a_q_out, b_i_out, b_q_out, mon_len [4];
	logic		a_valid_out, b_valid_out, irq_out, s_axi_awready_out, s_axi_wready_out;
	logic		range_flag_a_zero_out, range_flag_a_one_out;
	logic		range_flag_b_zero_out, range_flag_b_one_out;
	logic	[1:0]	a_ctrl_out, b_ctrl_out, s_axi_bresp_out, s_axi_rresp_out;
	logic		s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
	logic		s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
	logic		s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic	[11:0]	s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
	logic	[31:0]	s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic	[3:0]	s_axi_wstrb_in = 4'hF, mon_done;
	logic	[7:0]	li, lq;
	logic	[33:0]	qr [$];
	logic	[67:0]	qs [$], qe;
	logic	[15:0]	qp [4][$];
	int		err_total = 0, n_compared = 0, seed;
	localparam logic [11:0] A_LI = {IDX_LEVEL_LIMIT_I, 2'h0}, A_LQ = {IDX_LEVEL_LIMIT_Q, 2'h0};
	localparam logic [11:0] A_CF = {IDX_RANGE_PIN_CFG, 2'h0}, A_ST = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] A_MK = {IDX_IRQ_MASK, 2'h0};
	always #12.5 clk_sys_in = ~clk_sys_in;
	ord_overrange_detector i_ord_overrange_detector (.clk_sys_in, .rst_in, .a_valid_in,
		.a_i_in, .a_q_in, .b_valid_in, .b_i_in, .b_q_in, .a_valid_out, .a_i_out, .a_q_out,
		.a_ctrl_out, .b_valid_out, .b_i_out, .b_q_out, .b_ctrl_out, .range_flag_a_zero_out,
		.range_flag_a_one_out, .range_flag_b_zero_out, .range_flag_b_one_out, .irq_out,
		.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in,
		.s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out, .s_axi_bready_in,
		.s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in,
		.s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out);
	ord_pin_monitor i_ord_pin_monitor (.clk_sys_in, .rst_in, .pins_in({range_flag_b_one_out,
		range_flag_b_zero_out, range_flag_a_one_out, range_flag_a_zero_out}),
		.done_out(mon_done), .len_out(mon_len));
	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task close_out;
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// most negative code has no positive twin, so it reads as full scale
	function automatic logic [7:0] t8(input logic [15:0] s);
		logic [15:0] m;
		m = s[15] ? -s : s;
		return (s == 16'h8000) ? 8'hFF : m[14:7];
	endfunction : t8
	task automatic smp(input logic v, input logic [15:0] ai, aq, bi, bq);
		if (v)
			qs.push_back({t8(aq) >= lq, t8(ai) >= li, t8(bq) >= lq, t8(bi) >= li,
				ai, aq, bi, bq});
		a_valid_in <= v;
		b_valid_in <= v;
		a_i_in <= ai;
		a_q_in <= aq;
		b_i_in <= bi;
		b_q_in <= bq;
		@(posedge clk_sys_in);
	endtask : smp
	task automatic axw(input logic [11:0] ad, input logic [7:0] d, input logic [1:0] er);
		s_axi_awaddr_in <= ad;
		s_axi_wdata_in <= {24'h0, d};
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		do
		begin
			@(posedge clk_sys_in);
			if (s_axi_awready_out)
				s_axi_awvalid_in <= 1'h0;
			if (s_axi_wready_out)
				s_axi_wvalid_in <= 1'h0;
		end while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'h0;
		chk("bresp", s_axi_bresp_out, er);
		@(posedge clk_sys_in);
	endtask : axw
	task automatic axr(input logic [11:0] ad, input logic [33:0] e);
		qr.push_back(e);
		s_axi_araddr_in <= ad;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		do
		begin
			@(posedge clk_sys_in);
			if (s_axi_arready_out)
				s_axi_arvalid_in <= 1'h0;
		end while (!s_axi_rvalid_out);
		s_axi_rready_in <= 1'h0;
		@(posedge clk_sys_in);
	endtask : axr
	always @(posedge clk_sys_in)
	begin
		if (s_axi_rvalid_out && s_axi_rready_in)
			chk("read", {s_axi_rresp_out, s_axi_rdata_out}, qr.size() ? qr.pop_front() : 'x);
		if (a_valid_out)
		begin
			qe = qs.size() ? qs.pop_front() : 'x;
			chk("sample", {a_ctrl_out, b_ctrl_out, a_i_out}, 34'(qe[67:48]));
			chk("a_q", {b_valid_out, a_q_out}, {18'h1, qe[47:32]});
			chk("b_i", b_i_out, 34'(qe[31:16]));
			chk("b_q", b_q_out, 34'(qe[15:0]));
		end
		for (int l = 0; l < 4; l++)
			if (mon_done[l])
				chk("pulse", mon_len[l], qp[l].size() ? qp[l].pop_front() : 'x);
	end
	initial
	begin
		seed = $urandom(32'hCEE2);
		repeat (6) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		@(posedge clk_sys_in);
		axr(A_LI, 34'hF2);
		axr(A_LQ, 34'hAB);
		axr(A_CF, 34'h07);
		axr(A_MK, 34'h0);
		axr(12'h900, {RESP_SLVERR, 32'h0});
		axw(12'h900, 8'h55, RESP_SLVERR);
		// a write without its low byte lane leaves the register alone
		s_axi_wstrb_in <= 4'hE;
		axw(A_LI, 8'h11, RESP_OKAY);
		s_axi_wstrb_in <= 4'hF;
		axr(A_LI, 34'hF2);
		li = 8'hF2;
		lq = 8'hAB;
		// pins stay disabled here, so any pulse the monitor sees is a fault
		for (int k = 0; k < 8; k++)
		begin
			if (k > 0)
			begin
				li = 8'($urandom);
				lq = 8'($urandom);
				axw(A_LI, li, RESP_OKAY);
				axw(A_LQ, lq, RESP_OKAY);
			end
			smp(1'h1, {1'h0, li, 7'h0}, -{1'h0, lq, 7'h0}, {1'h0, li - 8'h1, 7'h7F}, 16'h8000);
			repeat (6) smp(1'($urandom), 16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom));
			smp(1'h0, 16'h0, 16'h0, 16'h0, 16'h0);
		end
		li = 8'h80;
		lq = 8'h80;
		axw(A_LI, li, RESP_OKAY);
		axw(A_LQ, lq, RESP_OKAY);
		repeat (1100) @(posedge clk_sys_in);
		axw(A_ST, 8'h0F, RESP_OKAY);
		// lane 0 hit twice, four cycles apart, to show the reload
		for (int e = 0; e < 8; e++)
		begin
			axw(A_CF, 8'hA8 | 8'(e), RESP_OKAY);
			axr(A_CF, 34'hA8 | 34'(e));
			qp[0].push_back(16'((8 << e) + 4));
			qp[3].push_back(16'(8 << e));
			smp(1'h1, 16'h7FFF, 16'h0, 16'h0, 16'h8000);
			repeat (3) smp(1'h0, 16'h0, 16'h0, 16'h0, 16'h0);
			smp(1'h1, 16'h7FFF, 16'h0, 16'h0, 16'h0);
			smp(1'h0, 16'h0, 16'h0, 16'h0, 16'h0);
			repeat ((8 << e) + 8) @(posedge clk_sys_in);
		end
		axr(A_ST, 34'h9);
		chk("irq", irq_out, 34'h0);
		axw(A_MK, 8'h01, RESP_OKAY);
		chk("irq", irq_out, 34'h1);
		axw(A_ST, 8'h01, RESP_OKAY);
		chk("irq", irq_out, 34'h0);
		axr(A_ST, 34'h8);
		close_out;
	end
	initial
	begin
		repeat (30000) @(posedge clk_sys_in);
		err_total++;
		close_out;
	end
endmodule : tb_overrange_detector
bind ord_overrange_detector ord_overrange_detector_chk #(.SAMPLE_W(SAMPLE_W)) i_chk (.clk_sys_in,
	.rst_in, .a_valid_in, .a_i_in, .b_valid_in, .b_q_in, .a_valid_out, .a_i_out, .a_ctrl_out,
	.b_ctrl_out, .range_flag_a_zero_out, .range_flag_b_one_out, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out);
